/* hdl/cpu_mode_access_checker.sv */
// Grants or denies each CPU memory and SFR access by CPU mode
// Assumes one AHB-Lite master and a CPU that obeys the grant outputs
// How it works
// R1: Contactless OS reads 64-byte access matrix
// R2: Contactless OS uses the exchange RAM window
// R3: Boot, contactless OS read the security row
// R4: Coprocessor reads EEPROM, owns its RAM
// R5: Boot mode reaches every SFR group except segmentation
// R6: Test mode reaches every SFR group except segmentation
// R7: Contactless OS: firewall read, own regs rw
// R8: Contactless OS hardware SFRs follow firewall bits
// R9: System mode reaches its five SFR groups
// R10: User hardware SFRs follow segment rights
// R11: General CPU registers open in all modes
// R12: Status high readable in contactless, user
// R13: Clock select readable in contactless OS
// R14: Segmentation registers only in system mode
// R15: System pointers never read back
// R16: Random number register ignores writes
// R17: Cipher keys never read back
// R18: Segment table address resets to zero
// R19: Memory partition fixed, never configurable
// R20: Segment table memory obeys segment rights
// R21: Denied read gives zero, write ignored
// R22: Five modes from status high, bits
// R23: Up to 64 segments with rights
// R24: Decision in the same cycle
`timescale 1ns/100ps
`include "cam_regs.svh"
module cpu_mode_access_checker (
    input wire logic CLOCK_I,
    input wire logic RESET_N_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    input wire logic [1:0] MODE_BITS_I,
    input wire logic SFR_SEL_I,
    input wire logic SFR_WR_I,
    input wire logic [7:0] SFR_ADDR_I,
    input wire logic [7:0] SFR_VALUE_I,
    output logic SFR_GRANT_O,
    output logic SFR_WE_O,
    output logic [7:0] SFR_RDATA_O,
    input wire logic MEM_SEL_I,
    input wire logic [1:0] MEM_OP_I,
    input wire logic [19:0] MEM_ADDR_I,
    input wire logic MEM_COPROC_I,
    input wire logic SEG_RD_I,
    input wire logic SEG_WR_I,
    input wire logic SEG_EX_I,
    input wire logic [15:0] SEG_HW_I,
    output logic MEM_GRANT_O,
    output logic [2:0] MODE_O
);
    cam_pkg::state_s st_r;
    cam_pkg::state_s st_nxt;
    cam_pkg::mode_e mode;
    cam_pkg::sfr_grp_e grp;
    logic [`NRGN-1:0] hit;
    logic [19:0] rbase [`NRGN];
    logic [19:0] rlen [`NRGN];
    logic [19:0] xbase;
    logic [19:0] xlen;
    logic [15:0] fw_bits;
    logic [3:0] hw_idx;
    logic priv;
    logic seg_on;
    logic sfr_ok;
    logic mem_ok;
    logic bus_cap;
    logic deny_ev;

    // Mode of the running code [R22]
    cpu_mode_decode u_mode (
        .program_status_high_i(st_r.program_status_high),
        .mode_bits_i(MODE_BITS_I),
        .mode_o(mode)
    );

    // Shared helpers for the decisions
    assign priv = (mode == cam_pkg::M_BOOT) || (mode == cam_pkg::M_TEST);
    assign seg_on = {st_r.seg_table_high, st_r.seg_table_low} != 16'h0000;
    assign fw_bits = {st_r.firewall_control_high, st_r.firewall_control_low};
    assign hw_idx = SFR_ADDR_I[5:2];
    assign MODE_O = 3'(mode);

    // Region table; partition bounds are constants only [R19]
    assign xbase = `ARAM_BASE
        + {4'h0, st_r.exchange_base_high, st_r.exchange_base_low};
    assign xlen = {4'h0, st_r.exchange_size_high, st_r.exchange_size_low};
    assign rbase = '{`TROM_BASE, `AROM_BASE, `CLEEP_BASE, `AEEP_BASE,
        `CLRAM_BASE, `ARAM_BASE, `CPRAM_BASE, `ACM_BASE, `SROW_BASE, xbase};
    assign rlen = '{`TROM_LEN, `AROM_LEN, `CLEEP_LEN, `AEEP_LEN,
        `CLRAM_LEN, `ARAM_LEN, `CPRAM_LEN, `ACM_LEN, `SROW_LEN, xlen};

    // One window compare per region
    for (genvar g = 0; g < `NRGN; g++) begin : g_rgn
        range_hit u_hit (
            .addr_i(MEM_ADDR_I),
            .base_i(rbase[g]),
            .len_i(rlen[g]),
            .hit_o(hit[g])
        );
    end

    // SFR group of an address
    function automatic cam_pkg::sfr_grp_e sfr_group(input logic [7:0] a);
        if (a >= `SFR_HW_LO) return cam_pkg::G_HW;
        else if (a >= `SFR_TST_LO) return cam_pkg::G_TST;
        else if (a >= `SFR_CLOS_LO) return cam_pkg::G_CLOS;
        else if (a >= `SFR_FWC_LO) return cam_pkg::G_FWC;
        else if (a >= `SFR_SMG_LO) return cam_pkg::G_SMG;
        else if (a >= `SFR_SEG_LO) return cam_pkg::G_SEG;
        else if (a >= `SFR_GEN_LO) return cam_pkg::G_GEN;
        else return cam_pkg::G_NONE;
    endfunction

    // SFR decision, combinational in the request cycle [R24]
    always_comb begin
        logic rd;
        rd = !SFR_WR_I;
        grp = sfr_group(SFR_ADDR_I);
        case (grp)
            cam_pkg::G_GEN: sfr_ok = 1'b1; // [R11]
            cam_pkg::G_SEG: sfr_ok = mode == cam_pkg::M_SYS; // [R14]
            cam_pkg::G_SMG: sfr_ok = priv || mode == cam_pkg::M_SYS // [R12]
                || (rd && SFR_ADDR_I == `SFR_PSW
                && (mode == cam_pkg::M_CL || mode == cam_pkg::M_USER));
            cam_pkg::G_FWC: sfr_ok = priv || mode == cam_pkg::M_SYS
                || (mode == cam_pkg::M_CL && rd); // [R7] [R9]
            cam_pkg::G_CLOS: sfr_ok = priv || mode == cam_pkg::M_CL; // [R7]
            cam_pkg::G_TST: sfr_ok = priv; // [R5] [R6]
            cam_pkg::G_HW: begin
                case (mode)
                    cam_pkg::M_CL: sfr_ok = fw_bits[hw_idx] // [R8]
                        || (rd && SFR_ADDR_I == `SFR_CLOCK_SELECT_REG); // [R13]
                    cam_pkg::M_USER: sfr_ok = seg_on
                        && SEG_HW_I[hw_idx]; // [R10]
                    default: sfr_ok = 1'b1; // [R5] [R6] [R9]
                endcase
            end
            default: sfr_ok = 1'b0;
        endcase
        // Fixed exceptions override the group rights
        if (rd && SFR_ADDR_I >= `SFR_PTR0 && SFR_ADDR_I <= `SFR_PTR2) begin
            sfr_ok = 1'b0; // [R15]
        end
        if (!rd && SFR_ADDR_I == `SFR_RNG) begin
            sfr_ok = 1'b0; // [R16]
        end
        if (rd && (SFR_ADDR_I == `SFR_KEY_A || SFR_ADDR_I == `SFR_KEY_D)) begin
            sfr_ok = 1'b0; // [R17]
        end
    end

    // Denied read yields zero, denied write gets no strobe
    assign SFR_GRANT_O = SFR_SEL_I && sfr_ok;
    assign SFR_WE_O = SFR_GRANT_O && SFR_WR_I; // [R21]
    assign SFR_RDATA_O = (SFR_GRANT_O && !SFR_WR_I) ? SFR_VALUE_I
        : 8'h00; // [R21]

    // Memory decision per mode, same cycle as the request [R24]
    always_comb begin
        logic rd;
        logic wr;
        logic ex;
        logic rom;
        logic eep;
        logic ram;
        rd = MEM_OP_I == `OP_RD;
        wr = MEM_OP_I == `OP_WR;
        ex = MEM_OP_I == `OP_EX;
        rom = hit[cam_pkg::RG_TROM] || hit[cam_pkg::RG_AROM];
        eep = hit[cam_pkg::RG_CLEEP] || hit[cam_pkg::RG_AEEP];
        ram = hit[cam_pkg::RG_CLRAM] || hit[cam_pkg::RG_ARAM]
            || hit[cam_pkg::RG_CPRAM];
        mem_ok = 1'b0;
        if (MEM_COPROC_I) begin
            mem_ok = (rd && eep)
                || (!ex && hit[cam_pkg::RG_CPRAM]); // [R4]
        end else begin
            case (mode)
                cam_pkg::M_BOOT, cam_pkg::M_CL: begin
                    mem_ok = (!wr && hit[cam_pkg::RG_TROM])
                        || hit[cam_pkg::RG_CLEEP]
                        || (!ex && hit[cam_pkg::RG_CLRAM])
                        || (rd && hit[cam_pkg::RG_SROW]); // [R3]
                    if (mode == cam_pkg::M_CL) begin
                        mem_ok = mem_ok
                            || (rd && hit[cam_pkg::RG_ACM]) // [R1]
                            || (!ex && hit[cam_pkg::RG_XWIN]
                            && hit[cam_pkg::RG_ARAM]); // [R2]
                    end
                end
                cam_pkg::M_TEST: mem_ok = (!wr && rom) || eep || (!ex && ram);
                cam_pkg::M_SYS: mem_ok = (!wr && hit[cam_pkg::RG_AROM])
                    || hit[cam_pkg::RG_AEEP]
                    || (!ex && hit[cam_pkg::RG_ARAM]);
                cam_pkg::M_USER: begin
                    // Rights of the executing segment entry [R23]
                    mem_ok = seg_on && ((rd && SEG_RD_I)
                        || (wr && SEG_WR_I) // [R20]
                        || (ex && SEG_EX_I)) // [R18]
                        && ((hit[cam_pkg::RG_AROM] && !wr)
                        || hit[cam_pkg::RG_AEEP]
                        || (hit[cam_pkg::RG_ARAM] && !ex));
                end
                default: mem_ok = 1'b0;
            endcase
        end
    end

    assign MEM_GRANT_O = MEM_SEL_I && mem_ok;
    assign deny_ev = (SFR_SEL_I && !sfr_ok) || (MEM_SEL_I && !mem_ok);

    // Bus register rights by mode
    function automatic logic bus_perm(input logic [7:0] idx, input logic wr,
        input cam_pkg::mode_e m);
        logic full;
        full = m == cam_pkg::M_BOOT || m == cam_pkg::M_TEST
            || m == cam_pkg::M_SYS;
        case (idx)
            `OFS_XBASE_LO, `OFS_XBASE_HI, `OFS_XSIZE_LO, `OFS_XSIZE_HI,
            `OFS_FW_LO, `OFS_FW_HI: return full || (m == cam_pkg::M_CL && !wr);
            `OFS_PSW: return full
                || (!wr && (m == cam_pkg::M_CL || m == cam_pkg::M_USER));
            `OFS_SEG_LO, `OFS_SEG_HI: return m == cam_pkg::M_SYS;
            `OFS_STATUS: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // Bus register read value
    function automatic logic [31:0] bus_read(input cam_pkg::state_s s,
        input logic [7:0] idx, input cam_pkg::mode_e m);
        case (idx)
            `OFS_XBASE_LO: return {24'h0, s.exchange_base_low};
            `OFS_XBASE_HI: return {24'h0, s.exchange_base_high};
            `OFS_XSIZE_LO: return {24'h0, s.exchange_size_low};
            `OFS_XSIZE_HI: return {24'h0, s.exchange_size_high};
            `OFS_FW_LO: return {24'h0, s.firewall_control_low};
            `OFS_FW_HI: return {24'h0, s.firewall_control_high};
            `OFS_PSW: return {24'h0, s.program_status_high};
            `OFS_SEG_LO: return {24'h0, s.seg_table_low};
            `OFS_SEG_HI: return {24'h0, s.seg_table_high};
            `OFS_STATUS: return {16'h0, s.deny_cnt, 1'b0, 3'(m), 3'h0,
                s.deny_flag};
            default: return 32'h0;
        endcase
    endfunction

    // Address phase taken on a word transfer with hready high
    assign bus_cap = HSEL_I && HTRANS_I[1] && HREADY_I
        && HSIZE_I == `HSIZE_WORD;
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = 1'b0;
    assign HRDATA_O = st_r.rdata;

    // Next state: data phase write, deny log, address capture
    always_comb begin
        st_nxt = st_r;
        if (st_r.ph_act && st_r.ph_wr
            && bus_perm(st_r.ph_idx, 1'b1, mode)) begin // [R21]
            case (st_r.ph_idx)
                `OFS_XBASE_LO: st_nxt.exchange_base_low = HWDATA_I[7:0];
                `OFS_XBASE_HI: st_nxt.exchange_base_high = HWDATA_I[7:0];
                `OFS_XSIZE_LO: st_nxt.exchange_size_low = HWDATA_I[7:0];
                `OFS_XSIZE_HI: st_nxt.exchange_size_high = HWDATA_I[7:0];
                `OFS_FW_LO: st_nxt.firewall_control_low = HWDATA_I[7:0];
                `OFS_FW_HI: st_nxt.firewall_control_high = HWDATA_I[7:0];
                `OFS_PSW: st_nxt.program_status_high = HWDATA_I[7:0];
                `OFS_SEG_LO: st_nxt.seg_table_low = HWDATA_I[7:0]; // [R14]
                `OFS_SEG_HI: st_nxt.seg_table_high = HWDATA_I[7:0];
                `OFS_STATUS: begin
                    if (HWDATA_I[0]) begin
                        st_nxt.deny_flag = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        // A new deny beats a clear in the same cycle
        if (deny_ev) begin
            st_nxt.deny_flag = 1'b1;
            if (st_r.deny_cnt != 8'hff) begin
                st_nxt.deny_cnt = st_r.deny_cnt + 8'h01;
            end
        end
        st_nxt.ph_act = bus_cap;
        st_nxt.ph_wr = HWRITE_I;
        st_nxt.ph_idx = (HADDR_I[31:8] == 24'h0) ? HADDR_I[7:0]
            : `OFS_UNMAPPED;
        if (bus_cap && !HWRITE_I) begin
            st_nxt.rdata = bus_perm(st_nxt.ph_idx, 1'b0, mode)
                ? bus_read(st_nxt, st_nxt.ph_idx, mode) : 32'h0; // [R21]
        end
    end

    // State register; all zero on reset, segment pointer too [R18]
    always_ff @(posedge CLOCK_I) begin
        if (!RESET_N_I) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (!RESET_N_I);

    sequence s_seg_wr_denied;
        bus_cap && HWRITE_I && mode != cam_pkg::M_SYS
            && (HADDR_I[7:0] == `OFS_SEG_LO || HADDR_I[7:0] == `OFS_SEG_HI);
    endsequence
    sequence s_fw_wr_cl;
        bus_cap && HWRITE_I && mode == cam_pkg::M_CL
            && HADDR_I[7:0] == `OFS_FW_LO && HADDR_I[31:8] == 24'h0;
    endsequence

    AST_SEG_SFR_SYS_ONLY: assert property ( // [R14]
        SFR_SEL_I && grp == cam_pkg::G_SEG && mode != cam_pkg::M_SYS
        |-> !SFR_GRANT_O && !SFR_WE_O)
        else $error("segmentation SFR granted outside system mode");
    AST_SEG_BUS_WR_IGNORED: assert property ( // [R14]
        s_seg_wr_denied ##1 mode != cam_pkg::M_SYS
        |=> $stable({st_r.seg_table_high, st_r.seg_table_low}))
        else $error("segment pointer changed outside system mode");
    AST_FW_RO_IN_CL: assert property ( // [R7]
        s_fw_wr_cl ##1 mode == cam_pkg::M_CL
        |=> $stable(st_r.firewall_control_low))
        else $error("firewall control written in contactless mode");
    AST_PTR_NOT_READ: assert property ( // [R15]
        SFR_SEL_I && !SFR_WR_I && SFR_ADDR_I >= `SFR_PTR0
        && SFR_ADDR_I <= `SFR_PTR2 |-> SFR_RDATA_O == 8'h00)
        else $error("system pointer value returned");
    AST_KEY_NOT_READ: assert property ( // [R17]
        SFR_SEL_I && !SFR_WR_I && (SFR_ADDR_I == `SFR_KEY_A
        || SFR_ADDR_I == `SFR_KEY_D) |-> !SFR_GRANT_O)
        else $error("cipher key read granted");
    AST_RNG_RO: assert property ( // [R16]
        SFR_SEL_I && SFR_WR_I && SFR_ADDR_I == `SFR_RNG |-> !SFR_WE_O)
        else $error("random number register write strobed");
    AST_DENY_ZERO: assert property ( // [R21]
        SFR_SEL_I && !SFR_GRANT_O |-> SFR_RDATA_O == 8'h00 && !SFR_WE_O)
        else $error("denied SFR access leaked data or strobe");
    AST_GEN_OPEN: assert property ( // [R11]
        SFR_SEL_I && grp == cam_pkg::G_GEN |-> SFR_GRANT_O)
        else $error("general CPU register denied");
    AST_USER_NO_SEG: assert property ( // [R18]
        MEM_SEL_I && !MEM_COPROC_I && mode == cam_pkg::M_USER && !seg_on
        |-> !MEM_GRANT_O)
        else $error("user access granted with no segment table");
    AST_DENY_LOGGED: assert property (
        deny_ev |=> st_r.deny_flag)
        else $error("denied access not logged");
endmodule // cpu_mode_access_checker

/* hdl/cam_regs.svh */
// Offsets, memory map, SFR map and reset values of the access checker
// Definitions only; included by the design files by bare name
`ifndef CAM_REGS_SVH
`define CAM_REGS_SVH
// Bus register byte offsets
`define OFS_XBASE_LO 8'h00
`define OFS_XBASE_HI 8'h04
`define OFS_XSIZE_LO 8'h08
`define OFS_XSIZE_HI 8'h0c
`define OFS_FW_LO 8'h10
`define OFS_FW_HI 8'h14
`define OFS_PSW 8'h18
`define OFS_SEG_LO 8'h1c
`define OFS_SEG_HI 8'h20
`define OFS_STATUS 8'h24
`define OFS_UNMAPPED 8'hfc
`define HSIZE_WORD 3'h2
`define RST_BYTE 8'h00
// Program status high fields and internal mode codes
`define PSW_CL_BIT 7
`define PSW_SYS_BIT 6
`define IMB_BOOT 2'h2
`define IMB_TEST 2'h3
// Memory operation codes
`define OP_RD 2'h0
`define OP_WR 2'h1
`define OP_EX 2'h2
// Fixed memory partition
`define NRGN 10
`define TROM_BASE 20'h00000
`define TROM_LEN 20'h10000
`define AROM_BASE 20'h10000
`define AROM_LEN 20'h30000
`define CLEEP_BASE 20'h40000
`define CLEEP_LEN 20'h01000
`define AEEP_BASE 20'h41000
`define AEEP_LEN 20'h1f000
`define CLRAM_BASE 20'h60000
`define CLRAM_LEN 20'h00800
`define ARAM_BASE 20'h60800
`define ARAM_LEN 20'h01800
`define CPRAM_BASE 20'h62000
`define CPRAM_LEN 20'h00400
`define ACM_BASE 20'h3ffc0
`define ACM_LEN 20'h00040
`define SROW_BASE 20'h41000
`define SROW_LEN 20'h00020
// SFR group bounds and fixed registers
`define SFR_GEN_LO 8'h80
`define SFR_SEG_LO 8'h90
`define SFR_SMG_LO 8'h98
`define SFR_FWC_LO 8'ha0
`define SFR_CLOS_LO 8'ha8
`define SFR_TST_LO 8'hb0
`define SFR_HW_LO 8'hc0
`define SFR_PSW 8'h98
`define SFR_PTR0 8'h99
`define SFR_PTR2 8'h9b
`define SFR_CLOCK_SELECT_REG 8'hc0
`define SFR_RNG 8'hc4
`define SFR_KEY_A 8'hc8
`define SFR_KEY_D 8'hcc
`endif

/* hdl/cam_pkg.sv */
// Types shared by the access checker files
// Needs nothing but the compiler
package cam_pkg;
    typedef enum logic [2:0] {M_BOOT, M_TEST, M_CL, M_SYS, M_USER} mode_e;
    typedef enum logic [2:0] {
        G_NONE, G_GEN, G_SEG, G_SMG, G_FWC, G_CLOS, G_TST, G_HW
    } sfr_grp_e;
    typedef enum int {
        RG_TROM, RG_AROM, RG_CLEEP, RG_AEEP, RG_CLRAM,
        RG_ARAM, RG_CPRAM, RG_ACM, RG_SROW, RG_XWIN
    } region_e;
    typedef struct packed {
        logic [7:0] exchange_base_low;
        logic [7:0] exchange_base_high;
        logic [7:0] exchange_size_low;
        logic [7:0] exchange_size_high;
        logic [7:0] firewall_control_low;
        logic [7:0] firewall_control_high;
        logic [7:0] program_status_high;
        logic [7:0] seg_table_low;
        logic [7:0] seg_table_high;
        logic deny_flag;
        logic [7:0] deny_cnt;
        logic ph_act;
        logic ph_wr;
        logic [7:0] ph_idx;
        logic [31:0] rdata;
    } state_s;
endpackage

/* hdl/range_hit.sv */
// Address window compare: base inclusive, length exclusive
// Assumes base plus length does not wrap the address space
`timescale 1ns/100ps
module range_hit (
    input wire logic [19:0] addr_i,
    input wire logic [19:0] base_i,
    input wire logic [19:0] len_i,
    output logic hit_o
);
    logic [19:0] ofs;

    // Offset from base, then length check
    assign ofs = addr_i - base_i;
    assign hit_o = (addr_i >= base_i) && (ofs < len_i);
endmodule // range_hit

/* hdl/cpu_mode_decode.sv */
// CPU mode from program status high and the two internal mode bits
// Assumes internal bits come from the CPU sequencer, stable per access
`timescale 1ns/100ps
`include "cam_regs.svh"
module cpu_mode_decode (
    input wire logic [7:0] program_status_high_i,
    input wire logic [1:0] mode_bits_i,
    output cam_pkg::mode_e mode_o
);
    // Internal bits win over the status word
    always_comb begin
        if (mode_bits_i == `IMB_BOOT) begin
            mode_o = cam_pkg::M_BOOT;
        end else if (mode_bits_i == `IMB_TEST) begin
            mode_o = cam_pkg::M_TEST;
        end else if (program_status_high_i[`PSW_CL_BIT]) begin
            mode_o = cam_pkg::M_CL;
        end else if (program_status_high_i[`PSW_SYS_BIT]) begin
            mode_o = cam_pkg::M_SYS;
        end else begin
            mode_o = cam_pkg::M_USER;
        end
    end
endmodule // cpu_mode_decode

/* tb/sfr_file_model.sv */
// CPU special function register file facing the access checker
// Assumes the checker's write strobe is the only write path into it
`timescale 1ns/100ps
module sfr_file_model (
    input wire logic clk_i,
    input wire logic sel_i,
    input wire logic [7:0] addr_i,
    input wire logic we_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] value_o
);
    logic [7:0] regs [256];
    // Distinct seed contents per register
    initial begin
        for (int i = 0; i < 256; i++) begin
            regs[i] = 8'(i) ^ 8'h5a;
        end
    end
    // Only granted writes land
    always @(posedge clk_i) begin
        if (sel_i && we_i) begin
            regs[addr_i] <= wdata_i;
        end
    end
    // Unselected file shows a scrambled value, never a stale one
    assign value_o = sel_i ? regs[addr_i] : ~regs[addr_i];
endmodule // sfr_file_model

/* tb/tb_top.sv */
// Self-checking bench for the CPU mode access checker
// Assumes same-cycle grants and a zero-wait bus slave
`timescale 1ns/100ps
`include "cam_regs.svh"
module tb_top;
    logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0, mode_bits = 2'h0, m_op = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic hready, hresp, s_sel = 1'b0, s_wr = 1'b0, s_grant, s_we;
    logic [7:0] s_addr = 8'h0, s_wd = 8'h0, s_val, s_rdata;
    logic m_sel = 1'b0, m_cop = 1'b0, seg_rd = 1'b1, m_grant;
    logic seg_wr = 1'b0, seg_ex = 1'b0;
    logic [19:0] m_addr = 20'h0;
    logic [15:0] seg_hw = 16'h0;
    logic [2:0] mode;
    int n_errors = 0, total_checks = 0, cycles = 0;

    // 250 MHz clock
    always #2 clk = ~clk;

    cpu_mode_access_checker u_dut (.CLOCK_I(clk), .RESET_N_I(rst_n),
        .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
        .HWRITE_I(hwrite), .HSIZE_I(`HSIZE_WORD), .HWDATA_I(hwdata),
        .HREADY_I(hready), .HRDATA_O(hrdata), .HREADYOUT_O(hready),
        .HRESP_O(hresp), .MODE_BITS_I(mode_bits), .SFR_SEL_I(s_sel),
        .SFR_WR_I(s_wr), .SFR_ADDR_I(s_addr), .SFR_VALUE_I(s_val),
        .SFR_GRANT_O(s_grant), .SFR_WE_O(s_we), .SFR_RDATA_O(s_rdata),
        .MEM_SEL_I(m_sel), .MEM_OP_I(m_op), .MEM_ADDR_I(m_addr),
        .MEM_COPROC_I(m_cop), .SEG_RD_I(seg_rd), .SEG_WR_I(seg_wr),
        .SEG_EX_I(seg_ex), .SEG_HW_I(seg_hw), .MEM_GRANT_O(m_grant),
        .MODE_O(mode));
    sfr_file_model u_sfr (.clk_i(clk), .sel_i(s_sel), .addr_i(s_addr),
        .we_i(s_we), .wdata_i(s_wd), .value_o(s_val));

    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end

    // One single bus transfer, address phase then data phase
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(rd, e);
        chk(32'(hresp), 32'h0);
    endtask

    // Mode change: status high written from boot, then bits applied
    task automatic set_mode(input logic [1:0] b, input logic [7:0] psw,
                            input logic [2:0] m, input logic [15:0] hw);
        @(posedge clk);
        mode_bits <= `IMB_BOOT;
        wr(`OFS_PSW, {24'h0, psw});
        mode_bits <= b;
        seg_hw <= hw;
        @(negedge clk);
        chk(32'(mode), 32'(m));
    endtask

    // SFR request judged in its own cycle
    task automatic sfr(input logic w, input logic [7:0] a, input logic g);
        logic [7:0] ev;
        @(posedge clk);
        s_sel <= 1'b1;
        s_wr <= w;
        s_addr <= a;
        s_wd <= ~a;
        @(negedge clk);
        ev = (!w && g) ? u_sfr.regs[a] : 8'h0;
        chk(32'({s_grant, s_we, s_rdata}), 32'({g, w & g, ev}));
    endtask

    // Memory request judged in its own cycle
    task automatic mem(input logic c, input logic [1:0] op,
                       input logic [19:0] a, input logic g);
        @(posedge clk);
        m_sel <= 1'b1;
        m_cop <= c;
        m_op <= op;
        m_addr <= a;
        @(negedge clk);
        chk(32'(m_grant), 32'(g));
    endtask

    // Read grants of each SFR group in every mode
    task automatic sfr_table();
        logic [7:0] ad [9] = '{`SFR_GEN_LO, `SFR_SEG_LO, `SFR_PSW,
            `SFR_PTR0, `SFR_FWC_LO, `SFR_CLOS_LO, `SFR_TST_LO, `SFR_RNG,
            `SFR_CLOCK_SELECT_REG};
        logic [1:0] mb [5] = '{`IMB_BOOT, `IMB_TEST, 2'h0, 2'h0, 2'h0};
        logic [7:0] ps [5] = '{8'h0, 8'h0, 8'h40, 8'h80, 8'h0};
        logic [2:0] md [5] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h4};
        logic [8:0] msk [5] = '{9'h1f5, 9'h1f5, 9'h197, 9'h135, 9'h005};
        for (int m = 0; m < 5; m++) begin
            set_mode(mb[m], ps[m], md[m], 16'h0);
            for (int i = 0; i < 9; i++) begin
                sfr(1'b0, ad[i], msk[m][i]);
            end
        end
        sfr(1'b0, `SFR_PSW, 1'b1);
        sfr(1'b1, `SFR_PSW, 1'b0);
    endtask

    // Firewall bits, exchange window, fixed exceptions, coprocessor
    task automatic firewall_and_memory();
        logic [23:0] t [18] = '{24'h13ffc0, 24'h13ffff, 24'h03ffbf,
            24'h23ffc0, 24'h141000, 24'h14101f, 24'h041020, 24'h241000,
            24'h160810, 24'h36082f, 24'h06080f, 24'h060830, 24'h950000,
            24'ha50000, 24'hb62000, 24'h9623ff, 24'h862400, 24'ha40000};
        logic [23:0] e;
        set_mode(`IMB_BOOT, 8'h0, 3'h0, 16'h0);
        mem(1'b0, `OP_RD, `SROW_BASE, 1'b1);
        mem(1'b0, `OP_RD, 20'h41020, 1'b0);
        sfr(1'b1, `SFR_RNG, 1'b0);
        sfr(1'b0, 8'h9a, 1'b0);
        sfr(1'b0, `SFR_PTR2, 1'b0);
        sfr(1'b0, `SFR_KEY_D, 1'b0);
        wr(`OFS_FW_LO, 32'h6);
        wr(`OFS_XBASE_LO, 32'h10);
        wr(`OFS_XSIZE_LO, 32'h20);
        set_mode(2'h0, 8'h80, 3'h2, 16'h0);
        wr(`OFS_FW_LO, 32'h0);
        rdc(`OFS_FW_LO, 32'h6);
        sfr(1'b1, `SFR_FWC_LO, 1'b0);
        sfr(1'b1, `SFR_CLOS_LO, 1'b1);
        sfr(1'b0, `SFR_CLOS_LO, 1'b1);
        sfr(1'b0, `SFR_RNG, 1'b1);
        sfr(1'b0, 8'hd0, 1'b0);
        sfr(1'b0, `SFR_CLOCK_SELECT_REG, 1'b1);
        sfr(1'b0, `SFR_KEY_A, 1'b0);
        for (int i = 0; i < 18; i++) begin
            e = t[i];
            mem(e[23], e[22:21], e[19:0], e[20]);
        end
        set_mode(2'h0, 8'h0, 3'h4, 16'h6);
        sfr(1'b0, `SFR_RNG, 1'b0);
        sfr(1'b0, 8'hd0, 1'b0);
        sfr(1'b0, `SFR_KEY_A, 1'b0);
    endtask

    // Segment pointer ownership, reset default and user memory
    task automatic segment_pointer();
        set_mode(2'h0, 8'h40, 3'h3, 16'h0);
        rdc(`OFS_SEG_LO, 32'h0);
        wr(`OFS_SEG_LO, 32'h1);
        rdc(`OFS_SEG_LO, 32'h1);
        rdc(`OFS_PSW, 32'h40);
        rdc(`OFS_UNMAPPED, 32'h0);
        set_mode(2'h0, 8'h0, 3'h4, 16'h6);
        sfr(1'b0, `SFR_RNG, 1'b1);
        sfr(1'b0, 8'hd0, 1'b0);
        rdc(`OFS_SEG_LO, 32'h0);
        wr(`OFS_SEG_LO, 32'h0);
        mem(1'b0, `OP_RD, `AROM_BASE, 1'b1);
        mem(1'b0, `OP_WR, 20'h50000, 1'b0);
        @(posedge clk);
        seg_wr <= 1'b1;
        seg_ex <= 1'b1;
        mem(1'b0, `OP_WR, 20'h50000, 1'b1);
        mem(1'b0, `OP_WR, `AROM_BASE, 1'b0);
        mem(1'b0, `OP_EX, `AROM_BASE, 1'b1);
        set_mode(`IMB_TEST, 8'h0, 3'h1, 16'h0);
        wr(`OFS_SEG_LO, 32'h0);
        set_mode(2'h0, 8'h40, 3'h3, 16'h0);
        rdc(`OFS_SEG_LO, 32'h1);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        mem(1'b0, `OP_RD, `AROM_BASE, 1'b0);
        set_mode(2'h0, 8'h40, 3'h3, 16'h0);
        rdc(`OFS_SEG_LO, 32'h0);
        ahb(1'b0, `OFS_STATUS, 32'h0);
        chk(rd & 32'hff, 32'h31);
    endtask

    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        mem(1'b0, `OP_RD, `AROM_BASE, 1'b0);
        chk(32'(mode), 32'h4);
        sfr_table();
        firewall_and_memory();
        segment_pointer();
        report_and_stop();
    end
endmodule // tb_top
